//--- design/mlc_loop_counters.sv
// Loop counter and loop suspend counter with Avalon-MM register slave.
// Assumes the sequencer supplies start, resume and loop-execute strobes on clock.
// Notes on behaviour
// R1: Either start event loads loop count value from its init value; the code loads it on start_event only, not on resume_event.
// R2: Counted loop with nonzero count decrements and branches to loop start.
// R3: Last loop, enable set, nonzero count: decrement and branch to loop start.
// R4: Last loop, enable set, count zero: stop execution.
// R5: Counted loop, enable set, count zero: stop execution.
// R6: Software sets up suspend register before enabling program execution.
// R7: Without suspension, software writes suspend init zero and enable zero.
// R8: For suspension software sets enable, mode zero, a continue enable, passes minus one.
// R9: Program start loads suspend count value from suspend init.
// R10: Any loop with suspension: zero suspends, else decrement and loop start.
// R11: Stop on stop event, such as address limit or loop count zero.
// R12: Alternate mode skips suspend decrement and suspension on last loops.
// R13: Suspend register: enable 31, init 23:16, read-only value 7:0.
// R14: Suspend counter acts on every kind of loop instruction.
// R15: Loop counter bit 31 enables count behaviour for last loops.
// R16: Loop counter bits 23:16 hold the software init value.
// R17: Resume event also reloads suspend count value from its init.
// R18: Comparison and decrement happen in the loop execute cycle.
`timescale 1ns/1ps
module mlc_loop_counters #(
    parameter int CNT_W = mlc_pkg::CNT_W
) (
    input  wire logic                          clock,
    input  wire logic                          rstn,
    input  wire logic [mlc_pkg::ADDR_W-1:0]    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    input  wire logic                          start_event,
    input  wire logic                          resume_event,
    input  wire logic                          alternate_mode_enable,
    input  wire logic                          limit_stop,
    input  wire mlc_pkg::mlc_loop_cmd_t        loop_cmd,
    output mlc_pkg::mlc_loop_res_t             loop_res,
    output logic [CNT_W-1:0]                   loop_count_value,
    output logic [CNT_W-1:0]                   suspend_count_value,
    output logic                               irq
);
    // ==========================================
    // Registers
    logic             last_loop_count_enable;
    logic [CNT_W-1:0] loop_count_init;
    logic             suspend_count_enable;
    logic [CNT_W-1:0] suspend_count_init;
    logic [mlc_pkg::IRQ_W-1:0] irq_status;
    logic [mlc_pkg::IRQ_W-1:0] irq_mask;
    logic             bus_done;
    logic             wr_hit;
    logic             rd_go;
    logic             is_loop;
    logic             is_last;
    logic             is_counted;
    logic             loop_count_zero;
    logic             suspend_count_zero;
    logic             cnt_active;
    logic             sus_active;
    logic             next_stop;
    logic             next_suspend;
    logic [mlc_pkg::IRQ_W-1:0] irq_events;

    // ==========================================
    // Next values and write strobes
    logic                      next_bus_done;
    logic                      next_waitrequest;
    mlc_pkg::mlc_loop_res_t    next_loop_res;
    logic [CNT_W-1:0]          next_loop_count_value;
    logic [CNT_W-1:0]          next_suspend_count_value;
    logic [mlc_pkg::IRQ_W-1:0] next_irq_status;
    logic                      next_irq;
    logic [31:0]               next_readdata;
    logic                      wr_loop_ctrl;
    logic                      wr_suspend_ctrl;
    logic                      wr_status;
    logic                      wr_mask;

    // ==========================================
    // Bus handshake: one wait cycle, then acknowledge
    assign wr_hit = avs_write && !avs_waitrequest && avs_byteenable[3] && avs_byteenable[2];
    assign rd_go  = avs_read && !bus_done;

    always_comb begin
        next_bus_done    = (avs_read || avs_write) && !bus_done;
        next_waitrequest = !next_bus_done;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            bus_done <= 1'b0;
        end else begin
            bus_done <= next_bus_done;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= next_waitrequest;
        end
    end

    // ==========================================
    // Write decode
    assign wr_loop_ctrl    = wr_hit && (avs_address == mlc_pkg::LOOP_COUNTER_CONTROL_OFS);
    assign wr_suspend_ctrl = wr_hit && (avs_address == mlc_pkg::LOOP_SUSPEND_CONTROL_OFS);
    assign wr_status       = wr_hit && (avs_address == mlc_pkg::IRQ_STATUS_OFS);
    assign wr_mask         = wr_hit && (avs_address == mlc_pkg::IRQ_MASK_OFS);

    // ==========================================
    // Loop decode and decisions
    always_comb begin
        is_loop    = 1'b0;
        is_last    = 1'b0;
        is_counted = 1'b0;
        if (loop_cmd.exec) begin
            case (loop_cmd.op)
                mlc_pkg::MLC_LOOP_OTHER: begin
                    is_loop = 1'b1; // R14
                end
                mlc_pkg::MLC_LOOP_LAST: begin
                    is_loop = 1'b1;
                    is_last = 1'b1;
                end
                mlc_pkg::MLC_COUNTED_LOOP_OP: begin
                    is_loop    = 1'b1;
                    is_counted = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // Counter zero detect
    assign loop_count_zero    = (loop_count_value == '0);
    assign suspend_count_zero = (suspend_count_value == '0);
    assign cnt_active = is_counted || (is_last && last_loop_count_enable); // R2 R3 R15
    assign sus_active = is_loop && suspend_count_enable
                        && !(is_last && alternate_mode_enable); // R12 R14

    always_comb begin
        next_stop    = 1'b0;
        next_suspend = 1'b0;
        if (is_last && limit_stop) begin
            next_stop = 1'b1; // R11
        end else if (cnt_active && loop_count_zero && (is_last || last_loop_count_enable)) begin
            next_stop = 1'b1; // R4 R5
        end else if (sus_active && suspend_count_zero) begin
            next_suspend = 1'b1; // R10
        end
    end

    // ==========================================
    // Loop result to sequencer
    always_comb begin
        next_loop_res               = '0;
        next_loop_res.stop          = next_stop;
        next_loop_res.suspend       = next_suspend;
        next_loop_res.to_loop_start = !next_stop && !next_suspend
                                      && ((cnt_active && !loop_count_zero) || sus_active); // R18
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            loop_res <= '0;
        end else begin
            loop_res <= next_loop_res;
        end
    end

    // ==========================================
    // Loop counter
    always_comb begin
        next_loop_count_value = loop_count_value;
        if (start_event) begin
            next_loop_count_value = loop_count_init; // R1
        end else if (cnt_active && !loop_count_zero && !next_stop) begin
            next_loop_count_value = loop_count_value - 1'b1; // R2 R3 R18
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            loop_count_value <= mlc_pkg::CNT_RESET;
        end else begin
            loop_count_value <= next_loop_count_value;
        end
    end

    // ==========================================
    // Suspend counter
    always_comb begin
        next_suspend_count_value = suspend_count_value;
        if (start_event || resume_event) begin
            next_suspend_count_value = suspend_count_init; // R9 R17
        end else if (sus_active && !suspend_count_zero && !next_stop) begin
            next_suspend_count_value = suspend_count_value - 1'b1; // R10 R18
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            suspend_count_value <= mlc_pkg::CNT_RESET;
        end else begin
            suspend_count_value <= next_suspend_count_value;
        end
    end

    // ==========================================
    // Software registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            last_loop_count_enable <= 1'b0;
            loop_count_init        <= mlc_pkg::CNT_RESET;
        end else if (wr_loop_ctrl) begin
            last_loop_count_enable <= avs_writedata[mlc_pkg::ENABLE_BIT]; // R15
            loop_count_init        <= avs_writedata[mlc_pkg::INIT_HI:mlc_pkg::INIT_LO]; // R16
        end
    end

    // ==========================================
    // Suspend control register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            suspend_count_enable <= 1'b0;
            suspend_count_init   <= mlc_pkg::CNT_RESET;
        end else if (wr_suspend_ctrl) begin
            suspend_count_enable <= avs_writedata[mlc_pkg::ENABLE_BIT]; // R13
            suspend_count_init   <= avs_writedata[mlc_pkg::INIT_HI:mlc_pkg::INIT_LO];
        end
    end

    // ==========================================
    // Interrupt mask register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= avs_writedata[mlc_pkg::IRQ_W-1:0];
        end
    end

    // ==========================================
    // Interrupt status, set wins over clear
    assign irq_events = {next_suspend, next_stop};

    for (genvar b = 0; b < mlc_pkg::IRQ_W; b++) begin : g_status
        assign next_irq_status[b] = irq_events[b]
                                    || (irq_status[b] && !(wr_status && avs_writedata[b]));
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // ==========================================
    // Interrupt output
    assign next_irq = |(irq_status & irq_mask);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // ==========================================
    // Read data
    always_comb begin
        next_readdata = mlc_pkg::DATA_ZERO;
        case (avs_address)
            mlc_pkg::LOOP_COUNTER_CONTROL_OFS: begin
                next_readdata[mlc_pkg::ENABLE_BIT] = last_loop_count_enable;
                next_readdata[mlc_pkg::INIT_HI:mlc_pkg::INIT_LO] = loop_count_init;
                next_readdata[mlc_pkg::VALUE_HI:mlc_pkg::VALUE_LO] = loop_count_value;
            end
            mlc_pkg::LOOP_SUSPEND_CONTROL_OFS: begin
                next_readdata[mlc_pkg::ENABLE_BIT] = suspend_count_enable; // R13
                next_readdata[mlc_pkg::INIT_HI:mlc_pkg::INIT_LO] = suspend_count_init;
                next_readdata[mlc_pkg::VALUE_HI:mlc_pkg::VALUE_LO] = suspend_count_value;
            end
            mlc_pkg::IRQ_STATUS_OFS: begin
                next_readdata[mlc_pkg::IRQ_W-1:0] = irq_status;
            end
            mlc_pkg::IRQ_MASK_OFS: begin
                next_readdata[mlc_pkg::IRQ_W-1:0] = irq_mask;
            end
            default: begin
                next_readdata = mlc_pkg::UNMAPPED;
            end
        endcase
    end

    // ==========================================
    // Read data register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            avs_readdata <= mlc_pkg::DATA_ZERO;
        end else if (rd_go) begin
            avs_readdata <= next_readdata;
        end
    end
endmodule

//--- design/mlc_pkg.sv
// Package for the memory self-test loop counter block.
// Assumes one clock and a synchronous active-low reset shared with the sequencer.
package mlc_pkg;
    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [3:0] LOOP_COUNTER_CONTROL_OFS = 4'h0;
    localparam logic [3:0] LOOP_SUSPEND_CONTROL_OFS = 4'h4;
    localparam logic [3:0] IRQ_STATUS_OFS           = 4'h8;
    localparam logic [3:0] IRQ_MASK_OFS             = 4'hc;
    localparam int         ADDR_W                   = 4;
    // ==========================================
    // Field positions
    localparam int ENABLE_BIT = 31;
    localparam int INIT_HI    = 23;
    localparam int INIT_LO    = 16;
    localparam int VALUE_HI   = 7;
    localparam int VALUE_LO   = 0;
    localparam int CNT_W      = 8;
    // ==========================================
    // Reset values
    localparam logic [7:0]  CNT_RESET = 8'h00;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED  = 32'h0000_0000;
    // ==========================================
    // Interrupt status bits
    localparam int IRQ_W       = 2;
    localparam int IRQ_STOP    = 0;
    localparam int IRQ_SUSPEND = 1;
    // ==========================================
    // Loop operation from the sequencer
    typedef enum logic [1:0] {
        MLC_LOOP_NONE,
        MLC_LOOP_OTHER,
        MLC_LOOP_LAST,
        MLC_COUNTED_LOOP_OP
    } mlc_loop_t;
    typedef struct packed {
        logic      exec;
        mlc_loop_t op;
    } mlc_loop_cmd_t;
    typedef struct packed {
        logic stop;
        logic suspend;
        logic to_loop_start;
    } mlc_loop_res_t;
endpackage

//--- test/mlc_chk.sv
// Assertion checker for the loop counter block.
// Assumes binding to the block's top module; init and enable fields mirror software writes.
`timescale 1ns/1ps
module mlc_chk #(
    parameter int CNT_W = 8
) (
    input wire logic                   clock,
    input wire logic                   rstn,
    input wire logic [3:0]             avs_address,
    input wire logic                   avs_write,
    input wire logic [31:0]            avs_writedata,
    input wire logic [3:0]             avs_byteenable,
    input wire logic                   avs_waitrequest,
    input wire logic                   start_event,
    input wire logic                   resume_event,
    input wire logic                   alternate_mode_enable,
    input wire logic                   limit_stop,
    input wire mlc_pkg::mlc_loop_cmd_t loop_cmd,
    input wire mlc_pkg::mlc_loop_res_t loop_res,
    input wire logic [CNT_W-1:0]       loop_count_value,
    input wire logic [CNT_W-1:0]       suspend_count_value
);
    // ==========================================
    // Mirror of the programmed fields
    logic [CNT_W-1:0] cnt_init, sus_init;
    logic             cnt_en, sus_en;
    wire wr_ok = avs_write && !avs_waitrequest && (&avs_byteenable[3:2]);
    wire x = loop_cmd.exec && !start_event && !resume_event;
    wire lst = x && loop_cmd.op == mlc_pkg::MLC_LOOP_LAST;
    wire cnt = x && loop_cmd.op == mlc_pkg::MLC_COUNTED_LOOP_OP;
    wire oth = x && loop_cmd.op == mlc_pkg::MLC_LOOP_OTHER;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            {cnt_en, cnt_init, sus_en, sus_init} <= '0;
        end else if (wr_ok && avs_address == 4'h0) begin
            {cnt_en, cnt_init} <= {avs_writedata[31], avs_writedata[23:16]};
        end else if (wr_ok && avs_address == 4'h4) begin
            {sus_en, sus_init} <= {avs_writedata[31], avs_writedata[23:16]};
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    start_load_a: assert property (start_event |=> loop_count_value == cnt_init
        && suspend_count_value == sus_init) else $error("start reload wrong");
    resume_load_a: assert property (resume_event && !start_event
        |=> suspend_count_value == sus_init) else $error("resume reload wrong");
    count_dec_a: assert property (cnt && loop_count_value != 0 && !sus_en
        |=> loop_count_value == $past(loop_count_value) - 1'b1 && loop_res.to_loop_start)
        else $error("counted loop decrement wrong");
    last_dec_a: assert property (lst && cnt_en && loop_count_value != 0 && !limit_stop
        && !sus_en |=> loop_count_value == $past(loop_count_value) - 1'b1)
        else $error("last loop decrement wrong");
    last_stop_a: assert property (lst && cnt_en && loop_count_value == 0
        |=> loop_res.stop) else $error("last loop did not stop");
    count_stop_a: assert property (cnt && cnt_en && loop_count_value == 0
        |=> loop_res.stop && $stable(loop_count_value)) else $error("counted loop stop wrong");
    limit_stop_a: assert property (lst && limit_stop |=> loop_res.stop)
        else $error("limit did not stop");
    susp_hit_a: assert property (oth && sus_en && suspend_count_value == 0
        |=> loop_res.suspend) else $error("no suspend at zero");
    susp_dec_a: assert property (oth && sus_en && suspend_count_value != 0
        |=> suspend_count_value == $past(suspend_count_value) - 1'b1)
        else $error("suspend decrement wrong");
    alt_mode_a: assert property (lst && alternate_mode_enable && sus_en
        |=> $stable(suspend_count_value) && !loop_res.suspend) else $error("alternate mode wrong");
endmodule
bind mlc_loop_counters mlc_chk #(.CNT_W(CNT_W)) mlc_chk_i (.*);

//--- test/testbench.sv
// Self-checking testbench for the loop counter block.
// Assumes the register slave answers with a one-cycle waitrequest low.
`timescale 1ns/1ps
module testbench;
    logic        clock, rstn, rd, wr, start_event, resume_event, alt, lim, wait_req, irq;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [7:0]  lcv, scv;
    int          failures = 0, checks_done = 0, cycles = 0;
    mlc_pkg::mlc_loop_cmd_t cmd;
    mlc_pkg::mlc_loop_res_t res;
    mlc_loop_counters mlc_loop_counters_i (.clock(clock), .rstn(rstn), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf),
        .avs_readdata(rdata), .avs_waitrequest(wait_req), .start_event(start_event),
        .resume_event(resume_event), .alternate_mode_enable(alt), .limit_stop(lim),
        .loop_cmd(cmd), .loop_res(res), .loop_count_value(lcv), .suspend_count_value(scv),
        .irq(irq));
    // ==========================================
    // Tasks
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge clock);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clock); while (wait_req !== 1'b0);
        q = rdata;
        rd <= 0;
        wr <= 0;
    endtask
    task automatic rdc(logic [3:0] a, logic [31:0] e, string n);
        bus(0, a, 0);
        chk(n, e, q);
    endtask
    task automatic lp(mlc_pkg::mlc_loop_t o, logic [2:0] e);
        @(posedge clock);
        cmd <= {1'b1, o};
        @(posedge clock);
        cmd <= '0;
        @(negedge clock);
        chk("loop_res", e, res);
    endtask
    task automatic go(logic s);
        @(posedge clock);
        start_event <= s;
        resume_event <= !s;
        @(posedge clock);
        start_event <= 0;
        resume_event <= 0;
        @(negedge clock);
    endtask
    task automatic end_sim;
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ==========================================
    // Clock, timeout and tests
    initial begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (++cycles > 5000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        {rstn, rd, wr, start_event, resume_event, alt, lim, addr, wdata, cmd} = '0;
        repeat (10) @(posedge clock);
        rstn <= 1;
        rdc(4'h0, 0, "loop_counter_control");
        rdc(4'h4, 0, "loop_suspend_control");
        bus(1, 4'h4, 32'h0000_0000);
        bus(1, 4'h0, 32'h8003_00ff);
        rdc(4'h0, 32'h8003_0000, "loop_counter_control");
        rdc(4'h2, 0, "unmapped");
        go(1);
        chk("loop_count_value", 3, lcv);
        for (int i = 2; i >= 0; i--) begin
            lp(mlc_pkg::MLC_COUNTED_LOOP_OP, 3'b001);
            chk("loop_count_value", i, lcv);
        end
        lp(mlc_pkg::MLC_COUNTED_LOOP_OP, 3'b100);
        chk("irq", 0, irq);
        rdc(4'h8, 1, "irq_status");
        bus(1, 4'hc, 3);
        repeat (2) @(negedge clock);
        chk("irq", 1, irq);
        bus(1, 4'h8, 1);
        repeat (2) @(negedge clock);
        chk("irq", 0, irq);
        go(1);
        lp(mlc_pkg::MLC_LOOP_LAST, 3'b001);
        chk("loop_count_value", 2, lcv);
        @(posedge clock) lim <= 1;
        lp(mlc_pkg::MLC_LOOP_LAST, 3'b100);
        @(posedge clock) lim <= 0;
        chk("loop_count_value", 2, lcv);
        repeat (2) lp(mlc_pkg::MLC_LOOP_LAST, 3'b001);
        lp(mlc_pkg::MLC_LOOP_LAST, 3'b100);
        bus(1, 4'h0, 32'h0001_0000);
        go(1);
        lp(mlc_pkg::MLC_LOOP_LAST, 3'b000);
        chk("loop_count_value", 1, lcv);
        bus(1, 4'h4, 32'h8001_00ff);
        go(1);
        rdc(4'h4, 32'h8001_0001, "loop_suspend_control");
        lp(mlc_pkg::MLC_LOOP_OTHER, 3'b001);
        chk("suspend_count_value", 0, scv);
        lp(mlc_pkg::MLC_LOOP_OTHER, 3'b010);
        rdc(4'h8, 3, "irq_status");
        go(0);
        chk("suspend_count_value", 1, scv);
        lp(mlc_pkg::MLC_LOOP_OTHER, 3'b001);
        @(posedge clock) alt <= 1;
        lp(mlc_pkg::MLC_LOOP_LAST, 3'b000);
        @(posedge clock) alt <= 0;
        lp(mlc_pkg::MLC_LOOP_LAST, 3'b010);
        end_sim();
    end
endmodule
